//--- logic/cacc_pkg.sv
// Package of constants, register map and carrier types for the coulomb accumulator
`default_nettype none
package cacc_pkg;
   // ==========================================================
   // Register offsets on the byte-wide register port
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h01;
   localparam logic [7:0] ADDR_CLEAR = 8'h02;
   localparam logic [7:0] ADDR_OFFSET = 8'h0B;
   localparam logic [7:0] ADDR_NET0 = 8'h10;
   localparam logic [7:0] ADDR_CHG0 = 8'h14;
   localparam logic [7:0] ADDR_DIS0 = 8'h18;
   localparam logic [7:0] ADDR_CUR0 = 8'h1C;
   localparam logic [7:0] ADDR_AVG0 = 8'h1E;

   // ==========================================================
   // Field positions in the control byte (00h)
   localparam int CTRL_ENABLE_BIT = 2;
   localparam int CTRL_FILTER_LO = 3;
   localparam int CTRL_GAIN_LO = 5;
   // Field positions in the configuration byte (01h)
   localparam int CFG_BYPASS_BIT = 0;
   localparam int CFG_OSR_LO = 1;
   localparam int CFG_AVGCNT_LO = 3;
   localparam int CFG_MASK_LO = 5;
   // Clear bits (02h)
   localparam int CLR_NET_BIT = 0;
   localparam int CLR_CHG_BIT = 1;
   localparam int CLR_DIS_BIT = 2;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h10;
   localparam logic [7:0] OFFSET_RESET = 8'h00;

   // ==========================================================
   // Arithmetic layout
   localparam int FRAC_BITS = 6;
   localparam int SIDE_SHIFT = 2;
   localparam int STEP_W = 22;
   localparam int RECIP_SHIFT = 10;
   // 64/5 and 64/10.2 in units of 2^-10
   localparam logic [14:0] RECIP_DIV5 = 15'h3333;
   localparam logic [14:0] RECIP_DIV10P2 = 15'h1919;
   // Averaging counts per code, log2 (code 2'b10 gives 64)
   localparam logic [2:0] AVG_LOG2_C0 = 3'h4;
   localparam logic [2:0] AVG_LOG2_C1 = 3'h5;
   localparam logic [2:0] AVG_LOG2_C2 = 3'h6;
   localparam logic [2:0] AVG_LOG2_C3 = 3'h7;

   // ==========================================================
   // Carrier types
   typedef enum logic [1:0] {
      CACC_GAIN_LOW,
      CACC_GAIN_MID_A,
      CACC_GAIN_MID_B,
      CACC_GAIN_HIGH
   } cacc_gain_t;

   typedef struct packed {
      logic accum_enable;
      logic [1:0] filter_decim_sel;
      cacc_gain_t gain_sel;
      logic gain_scale_bypass;
      logic [1:0] oversample_sel;
      logic [1:0] avg_sample_count_sel;
      logic [2:0] accum_lowbit_mask;
   } cacc_cfg_t;

   typedef struct packed {
      logic avg_current_sign;
      logic [14:0] avg_current_magnitude;
   } cacc_avg_t;
endpackage : cacc_pkg
`default_nettype wire

//--- logic/cacc_accumulator.sv
// Coulomb accumulation stage: register file, scaling, masking, totals, block average
//
// What this block does
// - Accumulate only while enable bit set
// - Net total is readable 32-bit register
// - Step is current LSB times period/3600
// - Six hidden fractional bits below net total
// - Divide by 5 or 10.2 per gain
// - Bypass bit selects unscaled accumulation
// - Disabled: updates discarded, totals hold
// - Separate charge and discharge totals, same scaling
// - Side totals two bits coarser than net
// - Clear bit wipes all totals, any enable
// - Clear bit returns to zero itself
// - Fixed non-overlapping block average, not moving
// - Average is sign plus 15-bit magnitude
// - Interval is conversion time times count
// - Code 2'b10 averages 64 samples
// - Full 16-bit sample enters accumulation
// - Mask zeroes selectable low sample bits
// - Mask never touches readable current value
// - Masking truncates toward minus infinity
// - Manual offset added to every sample
// - Filter select chooses decimation and period
// - Each period updates current; net total too while enabled
// - No current output during converter latency
// - Current register MSB is direction
// - Gain select drives amplifier gain code
`timescale 1ns/1ns
`default_nettype none
module cacc_accumulator #(
   parameter int SAMPLE_W = 16,
   parameter int TOTAL_W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port from the serial front end
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Converter result, one pulse per conversion period
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample_value,
   input wire logic conv_settling,
   // Settings to the amplifier and converter
   output logic [1:0] amp_gain_sel,
   output logic [1:0] conv_filter_sel,
   output logic [1:0] conv_oversample_sel,
   // Block average result
   output logic avg_valid,
   output logic avg_current_sign,
   output logic [14:0] avg_current_magnitude
);

   localparam int ACC_W = TOTAL_W + cacc_pkg::FRAC_BITS;
   localparam int SIDE_W = ACC_W + cacc_pkg::SIDE_SHIFT;
   localparam int STEP_W = cacc_pkg::STEP_W;

   // Width budget: the net total keeps the hidden fraction below its visible
   // 32 bits; the side totals keep two more bits on top, so their visible
   // window sits two places higher and reads two bits coarser than the net one.
   // A step is at most a full-scale sample times 64, which fits STEP_W bits.

   // ==========================================================
   // Configuration registers
   // Unmapped addresses ignore writes; the clear address stores nothing
   cacc_pkg::cacc_cfg_t cfg;
   logic [7:0] manual_offset;
   logic [7:0] ctrl_byte;
   logic [7:0] cfg_byte;
   logic clear_req;

   // Control and config bytes as written, kept whole for read-back
   // Writes land on the strobe edge, so a setting acts from the next cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_byte <= cacc_pkg::CTRL_RESET;
         cfg_byte <= cacc_pkg::CFG_RESET;
         manual_offset <= cacc_pkg::OFFSET_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            cacc_pkg::ADDR_CTRL: ctrl_byte <= reg_wdata;
            cacc_pkg::ADDR_CFG: cfg_byte <= reg_wdata;
            cacc_pkg::ADDR_OFFSET: manual_offset <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Decode fields into the carrier struct
   // Pure wiring; every field comes straight from a register bit
   always_comb begin
      cfg.accum_enable = ctrl_byte[cacc_pkg::CTRL_ENABLE_BIT];
      cfg.filter_decim_sel = ctrl_byte[cacc_pkg::CTRL_FILTER_LO +: 2];
      cfg.gain_sel = cacc_pkg::cacc_gain_t'(ctrl_byte[cacc_pkg::CTRL_GAIN_LO +: 2]);
      cfg.gain_scale_bypass = cfg_byte[cacc_pkg::CFG_BYPASS_BIT];
      cfg.oversample_sel = cfg_byte[cacc_pkg::CFG_OSR_LO +: 2];
      cfg.avg_sample_count_sel = cfg_byte[cacc_pkg::CFG_AVGCNT_LO +: 2];
      cfg.accum_lowbit_mask = cfg_byte[cacc_pkg::CFG_MASK_LO +: 3];
   end

   // ==========================================================
   // Settings toward the amplifier and converter
   // Straight from the register flip-flops, so they never glitch; the
   // converter owns the conversion period, so filter and oversample
   // settings reach the totals only through the pace of sample_valid.
   assign amp_gain_sel = cfg.gain_sel;
   assign conv_filter_sel = cfg.filter_decim_sel;
   assign conv_oversample_sel = cfg.oversample_sel;

   // ==========================================================
   // Clear strobe
   // Clearing wins over a preset and over accumulation in the same cycle
   // One-shot clear: any write with a clear bit set fires it for one cycle
   // Nothing is stored, so the bits read back as zero right away
   assign clear_req = reg_wr && (reg_addr == cacc_pkg::ADDR_CLEAR) &&
                      (reg_wdata[cacc_pkg::CLR_NET_BIT] || reg_wdata[cacc_pkg::CLR_CHG_BIT] ||
                       reg_wdata[cacc_pkg::CLR_DIS_BIT]);

   // ==========================================================
   // Sample path: offset, current register, mask, scale
   logic take_sample;
   logic signed [SAMPLE_W-1:0] offset_sample;
   logic signed [SAMPLE_W-1:0] current_value;
   logic signed [SAMPLE_W-1:0] masked_sample;
   logic [SAMPLE_W-1:0] mask_bits;
   logic signed [STEP_W-1:0] step;
   logic signed [STEP_W+15:0] scaled_prod;

   // Samples during converter settling are dropped entirely
   // No current, no total and no average count moves for them
   assign take_sample = sample_valid && !conv_settling;

   // Offset is sign-extended and applied to every sample.
   // The add wraps at the sample width: an offset that pushes a sample past
   // full scale folds it over, so keep the offset small against full scale.
   assign offset_sample = SAMPLE_W'($signed(sample_value) +
                          $signed({{(SAMPLE_W-8){manual_offset[7]}}, manual_offset}));

   // Readable current keeps the full unmasked word, two's complement
   // It updates whether or not accumulation is enabled
   always_ff @(posedge core_clk) begin
      if (rst) begin
         current_value <= '0;
      end else if (take_sample) begin
         current_value <= offset_sample;
      end
   end

   // Clearing low bits of a two's complement word floors it: positive
   // samples lose magnitude, negative ones gain it. Width 0 passes all bits.
   // The average uses the unmasked word, like the readable current.
   always_comb begin
      mask_bits = ~((SAMPLE_W'(1) << cfg.accum_lowbit_mask) - SAMPLE_W'(1));
      masked_sample = offset_sample & mask_bits;
   end

   // Step in units of the internal LSB; fixed-point reciprocal keeps the
   // divider out of the path at the cost of a tiny rounding error.
   // The internal LSB is a 64th of the visible one: an unscaled step is the
   // sample shifted up six places, a scaled one the sample times 64/divisor.
   // Gain codes 01 and 10 select the same amplifier gain, so share a divisor.
   always_comb begin
      scaled_prod = '0;
      case (cfg.gain_sel)
         cacc_pkg::CACC_GAIN_MID_A,
         cacc_pkg::CACC_GAIN_MID_B: begin
            scaled_prod = (STEP_W+16)'(masked_sample * $signed({1'b0, cacc_pkg::RECIP_DIV5}));
         end
         cacc_pkg::CACC_GAIN_HIGH: begin
            scaled_prod = (STEP_W+16)'(masked_sample * $signed({1'b0, cacc_pkg::RECIP_DIV10P2}));
         end
         default: begin
            scaled_prod = (STEP_W+16)'(masked_sample) <<< (cacc_pkg::FRAC_BITS + cacc_pkg::RECIP_SHIFT);
         end
      endcase
      if (cfg.gain_scale_bypass || cfg.gain_sel == cacc_pkg::CACC_GAIN_LOW) begin
         step = STEP_W'(masked_sample) <<< cacc_pkg::FRAC_BITS;
      end else begin
         step = STEP_W'(scaled_prod >>> cacc_pkg::RECIP_SHIFT);
      end
   end

   // ==========================================================
   // Totals
   // Each total updates on the edge that takes the sample
   logic [ACC_W-1:0] net_acc;
   logic [SIDE_W-1:0] chg_acc;
   logic [SIDE_W-1:0] dis_acc;
   logic accum_go;
   logic net_byte_wr;
   logic [1:0] net_byte_sel;
   logic [STEP_W-1:0] step_mag;

   assign accum_go = take_sample && cfg.accum_enable;
   assign net_byte_wr = reg_wr && (reg_addr[7:2] == cacc_pkg::ADDR_NET0[7:2]);
   assign net_byte_sel = reg_addr[1:0];
   assign step_mag = step[STEP_W-1] ? STEP_W'(-step) : step;

   // Totals wrap silently on overflow, as a free-running counter would
   // Net total: clear beats a host preset, preset beats accumulation.
   // A preset while enabled is honoured; software is expected to disable first
   // Any byte write zeroes the hidden fraction, so a preset starts clean
   always_ff @(posedge core_clk) begin
      if (rst) begin
         net_acc <= '0;
      end else if (clear_req) begin
         net_acc <= '0;
      end else if (net_byte_wr) begin
         net_acc[cacc_pkg::FRAC_BITS-1:0] <= '0;
         net_acc[cacc_pkg::FRAC_BITS + 8*net_byte_sel +: 8] <= reg_wdata;
      end else if (accum_go) begin
         net_acc <= net_acc + ACC_W'($signed(step));
      end
   end

   // Charge side: positive samples only, magnitude
   // Zero steps land here and add nothing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         chg_acc <= '0;
      end else if (clear_req) begin
         chg_acc <= '0;
      end else if (accum_go && !step[STEP_W-1]) begin
         chg_acc <= chg_acc + SIDE_W'(step_mag);
      end
   end

   // Discharge side: negative samples only, magnitude
   // Magnitude of the step, so this total only ever counts up
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dis_acc <= '0;
      end else if (clear_req) begin
         dis_acc <= '0;
      end else if (accum_go && step[STEP_W-1]) begin
         dis_acc <= dis_acc + SIDE_W'(step_mag);
      end
   end

   // Visible windows; side totals sit two bits coarser than the net one
   // Net keeps its fraction hidden; side windows drop two more bits
   logic [TOTAL_W-1:0] net_coulomb_total;
   logic [TOTAL_W-1:0] charge_in_total;
   logic [TOTAL_W-1:0] charge_out_total;
   assign net_coulomb_total = net_acc[ACC_W-1 -: TOTAL_W];
   assign charge_in_total = chg_acc[SIDE_W-1 -: TOTAL_W];
   assign charge_out_total = dis_acc[SIDE_W-1 -: TOTAL_W];

   // ==========================================================
   // Block average over a fixed count of samples
   logic [2:0] avg_log2;
   logic [7:0] avg_count;
   logic [7:0] avg_target;
   logic signed [SAMPLE_W+7:0] avg_sum;
   logic signed [SAMPLE_W+7:0] next_sum;
   logic signed [SAMPLE_W+7:0] avg_mean;
   cacc_pkg::cacc_avg_t avg_result;

   // Count select to log2 of samples per interval
   // Codes give 16, 32, 64 and 128 samples
   always_comb begin
      case (cfg.avg_sample_count_sel)
         2'h0: avg_log2 = cacc_pkg::AVG_LOG2_C0;
         2'h1: avg_log2 = cacc_pkg::AVG_LOG2_C1;
         2'h2: avg_log2 = cacc_pkg::AVG_LOG2_C2;
         default: avg_log2 = cacc_pkg::AVG_LOG2_C3;
      endcase
      avg_target = 8'(9'h001 << avg_log2) - 8'h01;
      next_sum = avg_sum + (SAMPLE_W+8)'($signed(offset_sample));
      avg_mean = next_sum >>> avg_log2;
   end

   // Sum restarts after each interval, so intervals never overlap.
   // A count code changed mid-interval acts at once: when the samples
   // already summed reach or pass the new count less one, the next sample closes
   // the interval, and the sum of all its samples is divided by the new count.
   // The sum is wide enough for the longest interval at full scale.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         avg_count <= '0;
         avg_sum <= '0;
      end else if (take_sample) begin
         if (avg_count >= avg_target) begin
            avg_count <= '0;
            avg_sum <= '0;
         end else begin
            avg_count <= avg_count + 8'h01;
            avg_sum <= next_sum;
         end
      end
   end

   // ==========================================================
   // Block average result
   // Result in sign and magnitude form, magnitude saturating at 15 bits.
   // The mean is floored, so a small negative average reads as magnitude one.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         avg_result <= '0;
         avg_valid <= 1'b0;
      end else begin
         avg_valid <= 1'b0;
         if (take_sample && avg_count >= avg_target) begin
            avg_valid <= 1'b1;
            avg_result.avg_current_sign <= avg_mean[SAMPLE_W+7];
            if (avg_mean[SAMPLE_W+7]) begin
               avg_result.avg_current_magnitude <= (-avg_mean > 24'sh007FFF) ? 15'h7FFF
                                                   : 15'(-avg_mean);
            end else begin
               avg_result.avg_current_magnitude <= (avg_mean > 24'sh007FFF) ? 15'h7FFF
                                                   : 15'(avg_mean);
            end
         end
      end
   end

   assign avg_current_sign = avg_result.avg_current_sign;
   assign avg_current_magnitude = avg_result.avg_current_magnitude;

   // ==========================================================
   // Read-back, one cycle after the read strobe
   // Multi-byte totals are not snapshotted; read while disabled for a clean word
   // Map: 00 control, 01 configuration, 02 clear (reads zero), 0B offset,
   // 10-13 net, 14-17 charge, 18-1B discharge, 1C-1D current, 1E-1F average;
   // every multi-byte value is little endian, anything else reads zero.
   logic [7:0] read_mux;

   always_comb begin
      read_mux = 8'h00;
      if (reg_addr[7:2] == cacc_pkg::ADDR_NET0[7:2]) begin
         read_mux = net_coulomb_total[8*reg_addr[1:0] +: 8];
      end else if (reg_addr[7:2] == cacc_pkg::ADDR_CHG0[7:2]) begin
         read_mux = charge_in_total[8*reg_addr[1:0] +: 8];
      end else if (reg_addr[7:2] == cacc_pkg::ADDR_DIS0[7:2]) begin
         read_mux = charge_out_total[8*reg_addr[1:0] +: 8];
      end else begin
         case (reg_addr)
            cacc_pkg::ADDR_CTRL: read_mux = ctrl_byte;
            cacc_pkg::ADDR_CFG: read_mux = cfg_byte;
            cacc_pkg::ADDR_CLEAR: read_mux = 8'h00;
            cacc_pkg::ADDR_OFFSET: read_mux = manual_offset;
            cacc_pkg::ADDR_CUR0: read_mux = current_value[7:0];
            8'h1D: read_mux = current_value[15:8];
            cacc_pkg::ADDR_AVG0: read_mux = avg_result[7:0];
            8'h1F: read_mux = avg_result[15:8];
            default: read_mux = 8'h00;
         endcase
      end
   end

   // Registered read data and its strobe; data holds until the next read,
   // so a slow host may take it any time before its next strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= read_mux;
         end
      end
   end

endmodule : cacc_accumulator
`default_nettype wire

//--- tb/cacc_sva.sv
// Checker of register port answers, settings outputs and block average pulses
`timescale 1ns/1ns
`default_nettype none
module cacc_sva #(
   parameter int SAMPLE_W = 16,
   parameter int TOTAL_W = 32
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // Sample stream
   input wire logic sample_valid,
   input wire logic [SAMPLE_W-1:0] sample_value,
   input wire logic conv_settling,
   // Settings and average
   input wire logic [1:0] amp_gain_sel,
   input wire logic [1:0] conv_filter_sel,
   input wire logic [1:0] conv_oversample_sel,
   input wire logic avg_valid,
   input wire logic avg_current_sign,
   input wire logic [14:0] avg_current_magnitude
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic acc;
   logic [7:0] taken;
   // ==========
   // Helpers
   // Accepted samples since the last average; saturates so it never wraps
   assign acc = sample_valid & ~conv_settling;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         taken <= 8'h00;
      end else if (avg_valid) begin
         taken <= {7'h00, acc};
      end else if (taken != 8'hFF) begin
         taken <= taken + {7'h00, acc};
      end
   end
   // ==========
   // Assertions
   rd_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read without answer");
   rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("answer without read");
   clear_reads_zero_a: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata == 8'h00)
      else $error("clear bits read nonzero");
   ctrl_fields_a: assert property (reg_wr && reg_addr == 8'h00 |=>
      amp_gain_sel == $past(reg_wdata[6:5]) && conv_filter_sel == $past(reg_wdata[4:3]))
      else $error("gain or filter select wrong");
   osr_field_a: assert property (reg_wr && reg_addr == 8'h01 |=>
      conv_oversample_sel == $past(reg_wdata[2:1])) else $error("oversample select wrong");
   settings_hold_a: assert property (!(reg_wr && reg_addr == 8'h00) |=>
      $stable(amp_gain_sel) && $stable(conv_filter_sel)) else $error("select moved");
   avg_block_a: assert property (avg_valid |-> taken >= 8'd16)
      else $error("average before block filled");
   avg_gap_a: assert property (avg_valid |=> !avg_valid [*8])
      else $error("average pulses too close");
   avg_hold_a: assert property (!avg_valid |-> $stable(avg_current_magnitude)
      && $stable(avg_current_sign)) else $error("average moved between pulses");
   rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved");
   // Main scenarios
   cover property (avg_valid);
   cover property (reg_wr && reg_addr == 8'h02);
   cover property (sample_valid && conv_settling);
endmodule : cacc_sva
bind cacc_accumulator cacc_sva #(.SAMPLE_W(SAMPLE_W), .TOTAL_W(TOTAL_W)) i_sva (.*);
`default_nettype wire

//--- tb/cacc_host.sv
// Host side model: byte writes and reads on the register port
`timescale 1ns/1ns
`default_nettype none
module cacc_host (
   // Clock
   input wire logic core_clk,
   // Register port toward the device
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // Idle port at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write strobe; released data is inverted so no stale byte lingers
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   // Read strobe, then a bounded wait for the answer
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end else begin
            @(negedge core_clk);
         end
      end
   endtask : rd
endmodule : cacc_host
`default_nettype wire

//--- tb/cacc_accumulator_tb_top.sv
// Self-checking bench of the coulomb accumulator against a reference model
`timescale 1ns/1ns
`default_nettype none
module cacc_accumulator_tb_top;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
   logic reg_wr, reg_rd, reg_rvalid, avg_valid, avg_current_sign;
   logic sample_valid = 1'b0;
   logic conv_settling = 1'b0;
   logic [15:0] sample_value = 16'h0000;
   logic [1:0] amp_gain_sel, conv_filter_sel, conv_oversample_sel;
   logic [14:0] avg_current_magnitude;
   logic [31:0] w;
   integer seed = 32'hE70C2E58;
   int failures = 0;
   int checked = 0;
   // Reference state: totals keep their hidden fraction bits
   longint net = 0, chg = 0, dis = 0;
   int sum = 0, cnt = 0, en = 0, gain = 0, byp = 0, msk = 0, off = 0;
   int lg = 6, raw = 0, nc = 0;
   logic [15:0] cur = 16'h0000, avg_exp = 16'h0000, avg_last = 16'h0000;
   logic pend = 1'b0;
   logic [7:0] ra [5] = '{8'h00, 8'h01, 8'h0B, 8'h05, 8'h02};
   logic [7:0] re [5] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
   always #10 core_clk = ~core_clk;
   cacc_accumulator i_dut (.*);
   cacc_host i_host (.*);
   // ==========
   // Checking and closing
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      logic ok;
      i_host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         failures++;
         $display("unexpected read answer expected 1 seen 0");
         summarize();
      end
   endtask : rd8
   // Little endian multi-byte read
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      logic [7:0] x;
      for (int i = 0; i < 4; i++) begin
         rd8(a + 8'(i), x);
         d[8*i +: 8] = x;
      end
   endtask : rd32
   // ==========
   // Sample stream, one per cycle, with the model stepped alongside
   task automatic tick;
      @(negedge core_clk);
      chk("average pulse", {31'h0, pend}, {31'h0, avg_valid});
      if (pend) begin
         chk("average", {16'h0, avg_exp}, {16'h0, avg_current_sign, avg_current_magnitude});
      end
      pend = 1'b0;
   endtask : tick
   task automatic smp(input int v, input logic settle);
      int s, m, st;
      tick();
      sample_valid = 1'b1;
      sample_value = v[15:0];
      conv_settling = settle;
      if (!settle) begin
         s = v + off;
         cur = s[15:0];
         sum += s;
         cnt++;
         if (cnt >= (1 << lg)) begin
            m = sum >>> lg;
            avg_exp = {m < 0, (m < 0) ? 15'(-m) : 15'(m)};
            avg_last = avg_exp;
            pend = 1'b1;
            sum = 0;
            cnt = 0;
         end
         m = s & ~((1 << msk) - 1);
         st = (byp || gain == 0) ? m * 64 : (m * (gain == 3 ? 6425 : 13107)) >>> 10;
         if (en) begin
            net += st;
            raw += v;
            nc++;
            if (st > 0) chg += st;
            else dis -= st;
         end
      end
   endtask : smp
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         smp($random(seed) % 3000, 1'b0);
      end
      smp($random(seed) % 3000, 1'b1);
      tick();
      sample_valid = 1'b0;
   endtask : burst
   task automatic chk_all;
      rd32(8'h10, w);
      chk("net total", net[37:6], w);
      rd32(8'h14, w);
      chk("charge total", chg[39:8], w);
      rd32(8'h18, w);
      chk("discharge total", dis[39:8], w);
      rd32(8'h1C, w);
      chk("current and average", {avg_last, cur}, w);
   endtask : chk_all
   // ==========
   // Main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      foreach (ra[i]) begin
         rd8(ra[i], b);
         chk("reset value", {24'h0, re[i]}, {24'h0, b});
      end
      burst(8);
      chk_all();
      for (int k = 0; k < 8; k++) begin
         gain = k % 4;
         byp = k / 4;
         en = 1;
         msk = $random(seed) & 7;
         off = $random(seed) % 64;
         i_host.wr(8'h00, 8'(32'h04 | gain << 5 | gain << 3));
         lg = 4 + gain;
         i_host.wr(8'h01, 8'(msk << 5 | gain << 3 | gain << 1 | byp));
         i_host.wr(8'h0B, 8'(off));
         burst(40);
         chk_all();
      end
      en = 0;
      i_host.wr(8'h00, 8'h00);
      w = $random(seed);
      for (int i = 0; i < 4; i++) begin
         i_host.wr(8'h10 + 8'(i), w[8*i +: 8]);
      end
      net = longint'(w) << 6;
      chk_all();
      gain = 3;
      byp = 0;
      en = 1;
      i_host.wr(8'h01, 8'(msk << 5 | gain << 3 | gain << 1 | byp));
      i_host.wr(8'h00, 8'h7C);
      burst(12);
      chk_all();
      i_host.wr(8'h02, 8'h01);
      net = 0;
      chg = 0;
      dis = 0;
      rd8(8'h02, b);
      chk("clear bits", 32'h0, {24'h0, b});
      chk_all();
      byp = 1;
      msk = 0;
      raw = 0;
      nc = 0;
      i_host.wr(8'h01, 8'(gain << 3 | gain << 1 | byp));
      burst(24);
      chk_all();
      rd32(8'h10, w);
      chk("corrected net", 32'(raw), w - 32'(off * nc));
      i_host.wr(8'h02, 8'h04);
      net = 0;
      chg = 0;
      dis = 0;
      chk_all();
      summarize();
   end
endmodule : cacc_accumulator_tb_top
`default_nettype wire
